// *** iscr_consts.svh ***
// Overview of operation
// R01: Page A upper byte holds gain scale
// R02: Page B bit 13 holds range select
// R03: Page B bits 12:8 hold offset trim
// R04: Trim decodes in 0.1 A two-sided steps
// R05: Low byte holds per-channel output limit
// R06: Only word reads and writes are served
// R07: Page 00h channel A, 01h channel B
// R08: Shunt selector in bits 15:14, page 0
// R09: Host selects page 0 for shunt word
// R10: Bits 12:0 are writable factory trim
// R11: Reported gain scales as scale over 50
// R12: Selector 11b, range 0 gives 0.5 mOhm
// R13: Telemetry uses the configured values
// R14: Range and selector pick eight gains
// R15: Host keeps gain scale at most 64d
// R16: Read-only bits ignore writes, read zero
//
// Purpose: offsets, fields, reset values of the input sense calibration bank
// Assumes: command codes arrive already decoded by the bus target engine
// Notes:   definitions only
`ifndef ISCR_CONSTS_SVH
`define ISCR_CONSTS_SVH

`define ISCR_CMD_SENSE_LIMIT   8'hDA
`define ISCR_CMD_SHUNT_GAIN    8'hDC
`define ISCR_PAGE_A            8'h00
`define ISCR_PAGE_B            8'h01

`define ISCR_SCALE_MSB         15
`define ISCR_SCALE_LSB         8
`define ISCR_RANGE_BIT         13
`define ISCR_TRIM_MSB          12
`define ISCR_TRIM_LSB          8
`define ISCR_LIMIT_MSB         7
`define ISCR_LIMIT_LSB         0
`define ISCR_SHUNT_MSB         15
`define ISCR_SHUNT_LSB         14
`define ISCR_FTRIM_MSB         12
`define ISCR_FTRIM_LSB         0

`define ISCR_MASK_PAGE_A       16'hFFFF
`define ISCR_MASK_PAGE_B       16'h3FFF
`define ISCR_MASK_SHUNT        16'hDFFF

`define ISCR_RST_PAGE_A        16'h3200
`define ISCR_RST_PAGE_B        16'h0000
`define ISCR_RST_SHUNT         16'hC000

`define ISCR_SCALE_NOMINAL     17'h00032
`define ISCR_TRIM_NEG_BIAS     6'h20

`endif

// *** iscr_pkg.sv ***
// Purpose: shared types of the input sense calibration bank
// Assumes: nothing beyond the constants header
// Notes:   gain codes count in units of 0.05 mOhm
package iscr_pkg;

  typedef enum logic [1:0] {
    ISCR_ACC_IDLE  = 2'b00,
    ISCR_ACC_WRITE = 2'b01,
    ISCR_ACC_READ  = 2'b10,
    ISCR_ACC_BAD   = 2'b11
  } iscr_access_t;

  typedef logic [6:0] iscr_gain_code_t;

endpackage

// *** iscr_gain_decode.sv ***
// Purpose: turns range, selector and trim code into gain and offset values
// Assumes: inputs come from the register bank on the same clock
// Notes:   purely combinational lookup
`timescale 1ns/100ps
module iscr_gain_decode (
  input  wire logic                    rangeSel,
  input  wire logic [1:0]              shuntSel,
  input  wire logic [4:0]              trimCode,
  output iscr_pkg::iscr_gain_code_t    gainCode,
  output logic signed [5:0]            offsetTenths
);

  // Effective analog gain in 0.05 mOhm steps
  always_comb begin
    case ({rangeSel, shuntSel})                // R14
      3'b000:  gainCode = 7'h03;               // 0.15
      3'b001:  gainCode = 7'h05;               // 0.25
      3'b010:  gainCode = 7'h06;               // 0.3
      3'b011:  gainCode = 7'h0A;               // R12
      3'b100:  gainCode = 7'h18;               // 1.2
      3'b101:  gainCode = 7'h28;               // 2.0
      3'b110:  gainCode = 7'h30;               // 2.4
      3'b111:  gainCode = 7'h50;               // 4.0
      default: gainCode = 7'h0A;
    endcase
  end

  // Upper half of codes maps to -1.6 A .. -0.1 A
  always_comb begin
    if (trimCode[4]) begin
      offsetTenths = $signed({2'b00, trimCode[3:0]}) - $signed(6'h10); // R04
    end else begin
      offsetTenths = $signed({2'b00, trimCode[3:0]});                  // R04
    end
  end

endmodule

// *** iscr_regs.sv ***
// Purpose: paged calibration and output-limit word registers
// Assumes: bus target engine hands over one decoded transaction per pulse
// Notes:   NVM image loads on nvmLoad; reset loads fixed defaults
`timescale 1ns/100ps
`include "iscr_consts.svh"
module iscr_regs (
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic                    cmdValid,
  input  wire logic [7:0]              cmdCode,
  input  wire logic [7:0]              cmdPage,
  input  wire logic                    cmdIsWord,
  input  wire logic                    cmdWrite,
  input  wire logic [15:0]             cmdWdata,
  output logic                         cmdClaim,
  output logic                         cmdInvalid,
  output logic                         rdValid,
  output logic [15:0]                  rdData,
  input  wire logic                    nvmLoad,
  input  wire logic [15:0]             nvmPageA,
  input  wire logic [15:0]             nvmPageB,
  input  wire logic [15:0]             nvmShunt,
  input  wire logic [15:0]             rawInputCurrent,
  output logic signed [16:0]           inputCurrent,
  output logic [7:0]                   outputLimitA,
  output logic [7:0]                   outputLimitB,
  output iscr_pkg::iscr_gain_code_t    analogGain
);

  logic [15:0]                cfgPageA;
  logic [15:0]                cfgPageB;
  logic [15:0]                shuntPage0;
  logic [15:0]                shuntPage1;
  logic                       hitSense;
  logic                       hitShunt;
  logic                       pageOk;
  iscr_pkg::iscr_access_t     access;
  logic signed [5:0]          offsetTenths;
  logic [15:0]                next_rdData;

  // Keep writable bits of new data, hold the rest at zero
  function automatic logic [15:0] merge(input logic [15:0] data, input logic [15:0] mask);
    merge = data & mask;
  endfunction

  // Write strobe for one copy: accepted write, matching code and page
  function automatic logic wrHit(input iscr_pkg::iscr_access_t kind,
                                 input logic                  hit,
                                 input logic [7:0]            page,
                                 input logic [7:0]            want);
    wrHit = (kind == iscr_pkg::ISCR_ACC_WRITE) && hit && (page == want);
  endfunction

  // Claim the two command codes on any page; pageOk marks the valid pages
  assign hitSense = (cmdCode == `ISCR_CMD_SENSE_LIMIT);
  assign hitShunt = (cmdCode == `ISCR_CMD_SHUNT_GAIN);
  assign pageOk   = (cmdPage == `ISCR_PAGE_A) || (cmdPage == `ISCR_PAGE_B); // R07
  assign cmdClaim = cmdValid && (hitSense || hitShunt);

  // Classify the access
  always_comb begin
    if (!cmdClaim) begin
      access = iscr_pkg::ISCR_ACC_IDLE;
    end else if (!cmdIsWord || !pageOk) begin
      access = iscr_pkg::ISCR_ACC_BAD;                    // R06
    end else if (cmdWrite) begin
      access = iscr_pkg::ISCR_ACC_WRITE;
    end else begin
      access = iscr_pkg::ISCR_ACC_READ;
    end
  end

  // Channel A copy of the sense/limit word
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfgPageA <= `ISCR_RST_PAGE_A;
    end else if (nvmLoad) begin
      cfgPageA <= merge(nvmPageA, `ISCR_MASK_PAGE_A);
    end else if (wrHit(access, hitSense, cmdPage, `ISCR_PAGE_A)) begin
      cfgPageA <= merge(cmdWdata, `ISCR_MASK_PAGE_A);     // R01 R05
    end
  end

  // Channel B copy of the sense/limit word
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfgPageB <= `ISCR_RST_PAGE_B;
    end else if (nvmLoad) begin
      cfgPageB <= merge(nvmPageB, `ISCR_MASK_PAGE_B);
    end else if (wrHit(access, hitSense, cmdPage, `ISCR_PAGE_B)) begin
      cfgPageB <= merge(cmdWdata, `ISCR_MASK_PAGE_B);     // R02 R03 R05 R16
    end
  end

  // Shunt gain word, page 0 copy drives the front end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shuntPage0 <= `ISCR_RST_SHUNT;
    end else if (nvmLoad) begin
      shuntPage0 <= merge(nvmShunt, `ISCR_MASK_SHUNT);
    end else if (wrHit(access, hitShunt, cmdPage, `ISCR_PAGE_A)) begin
      shuntPage0 <= merge(cmdWdata, `ISCR_MASK_SHUNT);    // R08 R10 R16
    end
  end

  // Page 1 shunt copy is stored but steers nothing
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shuntPage1 <= `ISCR_RST_SHUNT;
    end else if (wrHit(access, hitShunt, cmdPage, `ISCR_PAGE_B)) begin
      shuntPage1 <= merge(cmdWdata, `ISCR_MASK_SHUNT);    // R10 R16
    end
  end

  // Read mux
  always_comb begin
    if (hitShunt) begin
      next_rdData = (cmdPage == `ISCR_PAGE_A) ? shuntPage0 : shuntPage1;
    end else begin
      next_rdData = (cmdPage == `ISCR_PAGE_A) ? cfgPageA : cfgPageB;  // R07
    end
  end

  // Read answer and refusal flag, one cycle after the request
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdValid    <= 1'b0;
      rdData     <= 16'h0000;
      cmdInvalid <= 1'b0;
    end else begin
      rdValid    <= (access == iscr_pkg::ISCR_ACC_READ);       // R06
      cmdInvalid <= (access == iscr_pkg::ISCR_ACC_BAD);
      if (access == iscr_pkg::ISCR_ACC_READ) begin
        rdData <= next_rdData;
      end
    end
  end

  // Gain and offset lookup
  iscr_gain_decode uDecode (
    .rangeSel     (cfgPageB[`ISCR_RANGE_BIT]),
    .shuntSel     (shuntPage0[`ISCR_SHUNT_MSB:`ISCR_SHUNT_LSB]),
    .trimCode     (cfgPageB[`ISCR_TRIM_MSB:`ISCR_TRIM_LSB]),
    .gainCode     (analogGain),
    .offsetTenths (offsetTenths)
  );

  // Scaled input current in 0.1 A units: raw * scale / 50 + offset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      inputCurrent <= 17'sh00000;
    end else begin
      inputCurrent <= $signed(17'((24'(rawInputCurrent)
                        * 24'(cfgPageA[`ISCR_SCALE_MSB:`ISCR_SCALE_LSB]))
                        / 24'(`ISCR_SCALE_NOMINAL)))
                      + 17'(offsetTenths);                   // R11 R13
    end
  end

  // Per-channel output limit for output telemetry
  assign outputLimitA = cfgPageA[`ISCR_LIMIT_MSB:`ISCR_LIMIT_LSB];  // R05 R13
  assign outputLimitB = cfgPageB[`ISCR_LIMIT_MSB:`ISCR_LIMIT_LSB];  // R05 R13

endmodule

// *** iscr_regs_properties.sv ***
// Purpose: port checks on the calibration bank
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to every bank instance
`timescale 1ns/100ps
module iscr_regs_checker (
  input wire logic                      clk,
  input wire logic                      sys_rst,
  input wire logic                      cmdValid,
  input wire logic [7:0]                cmdCode,
  input wire logic [7:0]                cmdPage,
  input wire logic                      cmdIsWord,
  input wire logic                      cmdWrite,
  input wire logic [15:0]               cmdWdata,
  input wire logic                      cmdClaim,
  input wire logic                      cmdInvalid,
  input wire logic                      rdValid,
  input wire logic [15:0]               rdData,
  input wire logic                      nvmLoad,
  input wire logic [15:0]               nvmPageA,
  input wire logic [15:0]               nvmPageB,
  input wire logic [7:0]                outputLimitA,
  input wire logic [7:0]                outputLimitB,
  input wire iscr_pkg::iscr_gain_code_t analogGain
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Accepted word reads and writes
  wire logic okRead  = cmdValid && cmdClaim && cmdIsWord && !cmdWrite
                       && cmdPage < 8'h02;
  wire logic okWrite = cmdValid && cmdClaim && cmdIsWord && cmdWrite
                       && cmdPage < 8'h02 && !nvmLoad;
  chk_claim_decode: assert property (cmdClaim == (cmdValid
    && (cmdCode == 8'hDA || cmdCode == 8'hDC)))
    else $error("claim does not follow the code");
  chk_read_answer: assert property (okRead |=> rdValid && !cmdInvalid)
    else $error("read not answered");
  chk_refuse_pulse: assert property (cmdClaim && (!cmdIsWord || cmdPage > 8'h01)
    |=> cmdInvalid && !rdValid)
    else $error("bad access not refused");
  chk_answer_cause: assert property (rdValid |-> $past(okRead))
    else $error("read answer without request");
  chk_limit_a: assert property (okWrite && cmdCode == 8'hDA && cmdPage == 8'h00
    |=> outputLimitA == $past(cmdWdata[7:0]))
    else $error("channel A limit not written");
  chk_limit_b: assert property (okWrite && cmdCode == 8'hDA && cmdPage == 8'h01
    |=> outputLimitB == $past(cmdWdata[7:0]))
    else $error("channel B limit not written");
  chk_range_bit: assert property (okWrite && cmdCode == 8'hDA && cmdPage == 8'h01
    |=> (analogGain >= 7'h18) == $past(cmdWdata[13]))
    else $error("range bit does not steer gain");
  chk_page_b_ro: assert property (okRead && cmdCode == 8'hDA && cmdPage == 8'h01
    |=> rdData[15:14] == 2'b00)
    else $error("page B upper bits not zero");
  chk_unclaimed: assert property (cmdValid && !cmdClaim |=> !rdValid && !cmdInvalid)
    else $error("foreign code answered");
  chk_load_wins: assert property (nvmLoad |=> outputLimitA == $past(nvmPageA[7:0])
    && outputLimitB == $past(nvmPageB[7:0]))
    else $error("image load did not win");
  chk_shunt_ro: assert property (okRead && cmdCode == 8'hDC |=> rdData[13] == 1'b0)
    else $error("shunt bit 13 not zero");
endmodule
bind iscr_regs iscr_regs_checker u_iscr_regs_checker (.*);

// *** iscr_host_model.sv ***
// Purpose: bus host offering decoded word and non-word transactions
// Assumes: a request is taken at the first edge it is offered
// Notes:   idle data shows the inverse of its last value
`timescale 1ns/100ps
module iscr_host_model (
  input  wire logic        clk,
  output logic             cmdValid,
  output logic [7:0]       cmdCode,
  output logic [7:0]       cmdPage,
  output logic             cmdIsWord,
  output logic             cmdWrite,
  output logic [15:0]      cmdWdata,
  input  wire logic        rdValid,
  input  wire logic        cmdInvalid,
  input  wire logic [15:0] rdData
);
  initial {cmdValid, cmdCode, cmdPage, cmdIsWord, cmdWrite, cmdWdata} = 35'h0;
  // Drive after an edge, hold to the taking edge, then collect the answer
  task automatic xfer(input logic [7:0] c, input logic [7:0] p, input logic w, input logic wr,
                      input logic [15:0] d, output logic [15:0] rd, output logic inv);
    @(posedge clk);
    #1;
    {cmdValid, cmdCode, cmdPage} = {1'b1, c, p};
    {cmdIsWord, cmdWrite, cmdWdata} = {w, wr, d};
    @(posedge clk);
    #1;
    cmdValid = 1'b0;
    cmdWdata = ~cmdWdata;
    rd = rdValid ? rdData : 16'hXXXX;
    inv = cmdInvalid;
  endtask
endmodule

// *** testbench.sv ***
// Purpose: self-checking bench for the calibration bank
// Assumes: host model drives the bus, bench drives load and sense inputs
// Notes:   table rows first, then telemetry, gains, load and reset
`timescale 1ns/100ps
module testbench;
  typedef struct {logic [7:0] c; logic [7:0] p; logic w; logic wr; logic [15:0] d;
                  logic [15:0] e; logic i;} iscr_row_t;
  logic clk = 1'b0, sys_rst = 1'b1, nvmLoad = 1'b0, cmdValid, cmdIsWord, cmdWrite;
  logic cmdClaim, cmdInvalid, rdValid, inv;
  logic [7:0] cmdCode, cmdPage, outputLimitA, outputLimitB;
  logic [15:0] cmdWdata, rdData, rd, nvmPageA = 16'h1234, nvmPageB = 16'hFFFF;
  logic [15:0] nvmShunt = 16'h4000, rawInputCurrent = 16'h0064;
  logic signed [16:0] inputCurrent;
  iscr_pkg::iscr_gain_code_t analogGain;
  int n_errors = 0, tests_run = 0;
  logic [6:0] gains [8] = '{7'h03, 7'h05, 7'h06, 7'h0A, 7'h18, 7'h28, 7'h30, 7'h50};
  iscr_row_t rows [12] = '{'{8'hDA, 8'h00, 1'b1, 1'b0, 16'h0000, 16'h3200, 1'b0},
    '{8'hDC, 8'h00, 1'b1, 1'b0, 16'h0000, 16'hC000, 1'b0},
    '{8'hDA, 8'h00, 1'b1, 1'b1, 16'h40AB, 16'h0000, 1'b0},
    '{8'hDA, 8'h00, 1'b1, 1'b0, 16'h0000, 16'h40AB, 1'b0},
    '{8'hDA, 8'h01, 1'b1, 1'b1, 16'hFFC5, 16'h0000, 1'b0},
    '{8'hDA, 8'h01, 1'b1, 1'b0, 16'h0000, 16'h3FC5, 1'b0},
    '{8'hDC, 8'h00, 1'b1, 1'b1, 16'hFFFF, 16'h0000, 1'b0},
    '{8'hDC, 8'h00, 1'b1, 1'b0, 16'h0000, 16'hDFFF, 1'b0},
    '{8'hDA, 8'h02, 1'b1, 1'b0, 16'h0000, 16'h0000, 1'b1},
    '{8'hDA, 8'h00, 1'b0, 1'b0, 16'h0000, 16'h0000, 1'b1},
    '{8'hDA, 8'h00, 1'b0, 1'b1, 16'h0000, 16'h0000, 1'b1},
    '{8'hDA, 8'h00, 1'b1, 1'b0, 16'h0000, 16'h40AB, 1'b0}};
  iscr_regs u_iscr_regs (.*);
  iscr_host_model u_iscr_host_model (.*);
  // Free-running clock
  always #5 clk = ~clk;
  // Compare and count
  task automatic check(input logic [16:0] got, input logic [16:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("errors %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Word access through the host
  task automatic acc(input logic [7:0] c, input logic [7:0] p, input logic wr,
                     input logic [15:0] d);
    u_iscr_host_model.xfer(c, p, 1'b1, wr, d, rd, inv);
  endtask
  // Watchdog
  initial begin
    #100000;
    n_errors++;
    print_verdict();
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    #1 sys_rst = 1'b0;
    foreach (rows[k]) begin
      u_iscr_host_model.xfer(rows[k].c, rows[k].p, rows[k].w, rows[k].wr, rows[k].d, rd, inv);
      check(inv, rows[k].i, "refusal flag");
      if (!rows[k].wr && !rows[k].i) check(rd, rows[k].e, "read word");
    end
    check(outputLimitA, 8'hAB, "limit A");
    check(outputLimitB, 8'hC5, "limit B");
    // Foreign command code is neither claimed nor stored
    acc(8'hDB, 8'h00, 1'b1, 16'h0011);
    check(inv, 1'b0, "foreign code refused");
    check(outputLimitA, 8'hAB, "foreign code stored");
    acc(8'hDA, 8'h00, 1'b1, 16'h19AB);
    acc(8'hDA, 8'h01, 1'b1, 16'h1000);
    @(posedge clk);
    #1 check(inputCurrent, 17'h00022, "scaled current, negative trim");
    check(analogGain, 7'h0A, "gain 0.5");
    acc(8'hDA, 8'h00, 1'b1, 16'h40AB);
    acc(8'hDA, 8'h01, 1'b1, 16'h0F00);
    @(posedge clk);
    #1 check(inputCurrent, 17'h0008F, "full scale, positive trim");
    for (int g = 0; g < 8; g++) begin
      acc(8'hDA, 8'h01, 1'b1, {2'b00, g[2], 13'h0000});
      acc(8'hDC, 8'h00, 1'b1, {g[1:0], 14'h0000});
      check(analogGain, gains[g], "analog gain");
    end
    // Image load while a page A write lands in the same cycle
    nvmLoad = 1'b1;
    fork
      acc(8'hDA, 8'h00, 1'b1, 16'h0011);
      begin
        repeat (2) @(posedge clk);
        #1 nvmLoad = 1'b0;
      end
    join
    acc(8'hDA, 8'h01, 1'b0, 16'h0000);
    check(rd, 16'h3FFF, "loaded page B");
    acc(8'hDC, 8'h00, 1'b0, 16'h0000);
    check(rd, 16'h4000, "loaded shunt");
    check(outputLimitA, 8'h34, "loaded limit A");
    sys_rst = 1'b1;
    @(posedge clk);
    #1 sys_rst = 1'b0;
    acc(8'hDA, 8'h00, 1'b0, 16'h0000);
    check(rd, 16'h3200, "word after reset");
    check(analogGain, 7'h0A, "gain after reset");
    print_verdict();
  end
endmodule
